// File: pkg/reg_cmd_defines.svh
// Offsets, field positions, reset values and timing counts of the command interpreter.
`ifndef REG_CMD_DEFINES_SVH
`define REG_CMD_DEFINES_SVH

// ============================================================
// Primary register numbers
`define REG_OP_STATUS 8'h00
`define REG_DEV_TYPE 8'h01
`define REG_EXT_CFG 8'h09
`define REG_EXT_ADDR 8'h0A
`define REG_EXT_DATA 8'h0B
`define REG_FATAL 8'h20
`define REG_LONG_OP 8'h30
`define REG_SRQ_CFG 8'h31
`define REG_LABEL 8'h32
// Upper bounds of the generic and device-type ranges.
`define RANGE_GEN_LAST 8'h1F
`define RANGE_DEV_LAST 8'h7F

// ============================================================
// Error field codes, bits 3:0 of the operation status register
`define ERR_OK 4'h0
`define ERR_UNIMPL 4'h1
`define ERR_READ_ONLY 4'h2
`define ERR_PENDING 4'h4
`define ERR_EXT_RANGE 4'h6
`define ERR_EXT_RO 4'h7
`define ERR_EXEC_FAIL 4'h8
// Pending flag position in the operation status register.
`define STAT_PEND_BIT 8

// ============================================================
// Extended address space
`define EXT_HI_W 6
`define EXT_STEP 22'h00_0002
`define EXT_ONE 22'h00_0001
`define DT_BASE 22'h01_0000
`define DT_LEN 16'h0008
`define LB_BASE 22'h02_0000
`define LB_LEN 16'h0010
`define WORD_RESET 16'h0000

// ============================================================
// Long operation timing
`define LONG_OP_TIME_US 1000
`define CLK_MHZ 20
`define LONG_OP_CYCLES (`LONG_OP_TIME_US * `CLK_MHZ)

`endif

// File: pkg/reg_cmd_pkg.sv
// Types shared by the command interpreter.
package reg_cmd_pkg;
    // Two-bit status carried in every response.
    typedef enum logic [1:0] {
        ST_OK = 2'h0,
        ST_XE = 2'h1,
        ST_AEA = 2'h2,
        ST_PEND = 2'h3
    } rsp_status_t;
endpackage : reg_cmd_pkg

// File: design/register_command_interpreter.sv
// Application-layer register command interpreter with pending operations and extended access.
`timescale 1ns/1ps
`include "reg_cmd_defines.svh"
// Behaviour
// RULE_01: command is rw bit, register, 16 data.
// RULE_02: decode all 256 primary register numbers.
// RULE_03: generic, device-type, manufacturer register ranges.
// RULE_04: slow command answers at once, marked pending.
// RULE_05: keep answering commands while operation pending.
// RULE_06: status register reports pending and error.
// RULE_07: service request on failed pending op, if enabled.
// RULE_08: 22-bit extended address, high bits from configuration.
// RULE_09: extended address register holds low 16 bits.
// RULE_10: contents register reads/writes next 16 bits.
// RULE_11: host accesses field through contents register series.
// RULE_12: long-field read answers flag, length, presets pointer.
// RULE_13: read past field end gives error, zero.
// RULE_14: first write to long field presets pointer.
// RULE_15: successive contents writes store words in order.
// RULE_16: 16-bit big-endian values, bytes zero-extended.
// RULE_17: real values held as scaled integers.
// RULE_18: data over 16 bits only via extended access.
// RULE_19: text null-terminated, reads stop at field size.
// RULE_20: last error cause in status bits 3:0.
// RULE_21: unimplemented register gives error code one.
// RULE_22: service request holds until status cleared.
// RULE_23: response echoes the command register number.
module register_command_interpreter
    import reg_cmd_pkg::*;
#(
    parameter int LONG_OP_CYCLES = `LONG_OP_CYCLES,
    // Device type text; the value is arbitrary, null terminated.
    parameter logic [63:0] DEV_TYPE_TEXT = 64'h4142_4344_4546_4700
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_reg,
    input wire logic [15:0] i_cmd_data,
    input wire logic i_op_fault,
    output logic o_rsp_valid,
    output rsp_status_t o_rsp_status,
    output logic [7:0] o_rsp_reg,
    output logic [15:0] o_rsp_data,
    output logic o_srq_n
);

    // ============================================================
    // State
    logic [15:0] ext_cfg_q;    // Space select and high address bits.
    logic [15:0] ext_addr_q;   // Low 16 address bits.
    logic [15:0] long_op_q;    // Target of the long operation, scaled integer.
    logic srq_en_q;            // Service request on pending failure.
    logic pend_q;              // Long operation in progress.
    logic [23:0] pend_cnt_q;   // Cycles left of the long operation.
    logic [3:0] err_q;         // Cause of the last error.
    logic [7:0] label_mem [16];  // Writable text field.
    logic fault_s1_q;          // Fault pin synchroniser stages.
    logic fault_s2_q;
    logic fault_s3_q;
    logic fault_q;             // Filtered fault level.

    // ============================================================
    // Decode results
    rsp_status_t st_d;
    logic [15:0] data_d;
    logic [3:0] err_d;
    logic xe;          // Command ends in an execution error.
    logic start;       // Long operation launched.
    logic clr;         // Status clear written.
    logic ptr_we;      // Extended pointer written as a whole.
    logic [21:0] ptr_d;
    logic lbl_we;      // Label word write.
    logic [21:0] ptr;
    logic [4:0] dt_hit;
    logic [4:0] lb_hit;
    logic [63:0] dt_shift;
    logic fail;        // Pending operation ends in error.

    // Locate an address inside a field: bit 4 is a hit, bits 3:0 the offset.
    // Both bytes of the word must lie inside the field.
    function automatic logic [4:0] field_hit(input logic [21:0] a, input logic [21:0] base,
                                             input logic [15:0] len);
        logic [21:0] d;
        d = a - base;
        field_hit = {(a >= base) && ((d + `EXT_ONE) < {6'h00, len}), d[3:0]};
    endfunction : field_hit

    assign ptr = {ext_cfg_q[`EXT_HI_W-1:0], ext_addr_q};  // [RULE_08] [RULE_09]
    assign dt_hit = field_hit(ptr, `DT_BASE, `DT_LEN);
    assign lb_hit = field_hit(ptr, `LB_BASE, `LB_LEN);
    // Big-endian: the first byte of the field is the top byte of the word.
    assign dt_shift = DEV_TYPE_TEXT << {dt_hit[3:0], 3'b000};
    assign fail = pend_q && (pend_cnt_q == 24'h00_0001) && fault_q;

    // ============================================================
    // Command decode. Every register number is decoded; anything not
    // listed falls to the unimplemented answer in all three ranges.
    always_comb begin
        st_d = ST_OK;
        data_d = `WORD_RESET;
        err_d = `ERR_OK;
        xe = 1'b0;
        start = 1'b0;
        clr = 1'b0;
        ptr_we = 1'b0;
        ptr_d = ptr;
        lbl_we = 1'b0;
        case (i_cmd_reg)  // [RULE_02] [RULE_03]
            `REG_OP_STATUS: begin
                // Pending flag and last error cause; a write clears the error.
                data_d = {7'h00, pend_q, 4'h0, err_q};  // [RULE_06] [RULE_20]
                clr = i_cmd_write;
            end
            `REG_DEV_TYPE: begin
                if (i_cmd_write) begin
                    xe = 1'b1;
                    err_d = `ERR_READ_ONLY;
                end else begin
                    // Long field: answer its length and aim the pointer at it.
                    st_d = ST_AEA;  // [RULE_12] [RULE_18]
                    data_d = `DT_LEN;
                    ptr_we = 1'b1;
                    ptr_d = `DT_BASE;
                end
            end
            `REG_LABEL: begin
                // Read or first write both preset the pointer to the field.
                st_d = i_cmd_write ? ST_OK : ST_AEA;  // [RULE_14] [RULE_12]
                data_d = `LB_LEN;
                ptr_we = 1'b1;
                ptr_d = `LB_BASE;
            end
            `REG_EXT_CFG: data_d = ext_cfg_q;
            `REG_EXT_ADDR: data_d = ext_addr_q;
            `REG_EXT_DATA: begin
                if (!i_cmd_write && dt_hit[4]) begin
                    data_d = dt_shift[63:48];  // [RULE_10] [RULE_19]
                    ptr_we = 1'b1;
                    ptr_d = ptr + `EXT_STEP;
                end else if (lb_hit[4]) begin
                    data_d = {label_mem[lb_hit[3:0]], label_mem[lb_hit[3:0] + 4'h1]};
                    lbl_we = i_cmd_write;  // [RULE_15]
                    ptr_we = 1'b1;
                    ptr_d = ptr + `EXT_STEP;
                end else begin
                    // Past the field end, outside any field or a write into the type field: error, zero data.
                    xe = 1'b1;  // [RULE_13]
                    err_d = (i_cmd_write && dt_hit[4]) ? `ERR_EXT_RO : `ERR_EXT_RANGE;
                end
            end
            `REG_FATAL: begin
                data_d = {15'h0000, ~o_srq_n};
                if (i_cmd_write) begin
                    xe = 1'b1;
                    err_d = `ERR_READ_ONLY;
                end
            end
            `REG_LONG_OP: begin
                data_d = long_op_q;  // [RULE_17]
                if (i_cmd_write && pend_q) begin
                    xe = 1'b1;
                    err_d = `ERR_PENDING;
                end else if (i_cmd_write) begin
                    // Answer now and finish in the background.
                    st_d = ST_PEND;  // [RULE_04]
                    start = 1'b1;
                end
            end
            `REG_SRQ_CFG: data_d = {15'h0000, srq_en_q};  // [RULE_16]
            default: begin
                xe = 1'b1;
                err_d = `ERR_UNIMPL;  // [RULE_21]
            end
        endcase
        if (xe) begin
            st_d = ST_XE;
            data_d = `WORD_RESET;
        end
    end

    // ============================================================
    // Response. One answer per command, the cycle after it is taken,
    // whether or not an operation is pending.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rsp_valid <= 1'b0;
            o_rsp_status <= ST_OK;
            o_rsp_reg <= 8'h00;
            o_rsp_data <= `WORD_RESET;
        end else begin
            o_rsp_valid <= i_cmd_valid;  // [RULE_05] [RULE_01]
            if (i_cmd_valid) begin
                o_rsp_status <= st_d;
                o_rsp_reg <= i_cmd_reg;  // [RULE_23]
                o_rsp_data <= data_d;
            end
        end
    end

    // ============================================================
    // Extended pointer and host configuration registers.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ext_cfg_q <= `WORD_RESET;
            ext_addr_q <= `WORD_RESET;
            long_op_q <= `WORD_RESET;
            srq_en_q <= 1'b0;
        end else if (i_cmd_valid) begin
            if (ptr_we && !xe) begin
                // Auto-advance keeps the space select bits above the address.
                ext_cfg_q <= {ext_cfg_q[15:`EXT_HI_W], ptr_d[21:16]};  // [RULE_08]
                ext_addr_q <= ptr_d[15:0];  // [RULE_09]
            end else if (i_cmd_write && i_cmd_reg == `REG_EXT_CFG) begin
                ext_cfg_q <= i_cmd_data;
            end else if (i_cmd_write && i_cmd_reg == `REG_EXT_ADDR) begin
                ext_addr_q <= i_cmd_data;
            end
            if (start) begin
                long_op_q <= i_cmd_data;  // [RULE_17]
            end
            if (i_cmd_write && i_cmd_reg == `REG_SRQ_CFG) begin
                srq_en_q <= i_cmd_data[0];
            end
        end
    end

    // ============================================================
    // Label field storage; not reset, software fills it.
    always_ff @(posedge i_mclk) begin
        if (i_cmd_valid && lbl_we) begin
            label_mem[lb_hit[3:0]] <= i_cmd_data[15:8];  // [RULE_15] [RULE_16]
            label_mem[lb_hit[3:0] + 4'h1] <= i_cmd_data[7:0];
        end
    end

    // ============================================================
    // Fault pin: three stages, a change counts once stages two and three
    // agree, so a one-cycle glitch is never seen.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            fault_s1_q <= 1'b0;
            fault_s2_q <= 1'b0;
            fault_s3_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            fault_s1_q <= i_op_fault;
            fault_s2_q <= fault_s1_q;
            fault_s3_q <= fault_s2_q;
            if (fault_s2_q == fault_s3_q) begin
                fault_q <= fault_s3_q;
            end
        end
    end

    // ============================================================
    // Long operation timer.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pend_q <= 1'b0;
            pend_cnt_q <= 24'h00_0000;
        end else if (i_cmd_valid && start) begin
            pend_q <= 1'b1;  // [RULE_04]
            pend_cnt_q <= 24'(LONG_OP_CYCLES);
        end else if (pend_q) begin
            pend_cnt_q <= pend_cnt_q - 24'h00_0001;
            if (pend_cnt_q == 24'h00_0001) begin
                pend_q <= 1'b0;  // [RULE_06]
            end
        end
    end

    // ============================================================
    // Error field and service request. A failure in the clearing cycle
    // wins, so the host never loses it.
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            err_q <= `ERR_OK;
            o_srq_n <= 1'b1;
        end else begin
            if (fail) begin
                err_q <= `ERR_EXEC_FAIL;  // [RULE_20]
            end else if (i_cmd_valid && xe) begin
                err_q <= err_d;  // [RULE_21]
            end else if (i_cmd_valid && clr) begin
                err_q <= `ERR_OK;
            end
            if (fail && srq_en_q) begin
                o_srq_n <= 1'b0;  // [RULE_07]
            end else if (i_cmd_valid && clr) begin
                o_srq_n <= 1'b1;  // [RULE_22]
            end
        end
    end

    // ============================================================
    // Checks
    property p_rsp_echo;
        @(posedge i_mclk) disable iff (i_reset)
        i_cmd_valid |=> o_rsp_valid && o_rsp_reg == $past(i_cmd_reg);
    endproperty
    a_rsp_echo: assert property (p_rsp_echo) else $error("response missing or wrong register"); // [RULE_23]

    property p_unimpl;
        @(posedge i_mclk) disable iff (i_reset)
        i_cmd_valid && i_cmd_reg == 8'h21 && !fail |=> o_rsp_status == ST_XE && err_q == 4'h1;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented register not flagged"); // [RULE_21]

    property p_pend_start;
        @(posedge i_mclk) disable iff (i_reset)
        i_cmd_valid && i_cmd_write && i_cmd_reg == `REG_LONG_OP && !pend_q
            |=> o_rsp_status == ST_PEND && pend_q;
    endproperty
    a_pend_start: assert property (p_pend_start) else $error("long operation not pending"); // [RULE_04]

    property p_busy_answers;
        @(posedge i_mclk) disable iff (i_reset)
        pend_q && i_cmd_valid |=> o_rsp_valid;
    endproperty
    a_busy_answers: assert property (p_busy_answers) else $error("no answer while pending"); // [RULE_05]

    property p_pend_end;
        @(posedge i_mclk) disable iff (i_reset)
        pend_q && pend_cnt_q == 24'h00_0001 && !(i_cmd_valid && start) |=> !pend_q;
    endproperty
    a_pend_end: assert property (p_pend_end) else $error("pending flag did not drop"); // [RULE_06]

    property p_srq_cause;
        @(posedge i_mclk) disable iff (i_reset)
        $fell(o_srq_n) |-> $past(srq_en_q) && err_q == 4'h8;
    endproperty
    a_srq_cause: assert property (p_srq_cause) else $error("service request without failure"); // [RULE_07]

    property p_srq_hold;
        @(posedge i_mclk) disable iff (i_reset)
        !o_srq_n && !(i_cmd_valid && i_cmd_write && i_cmd_reg == `REG_OP_STATUS) |=> !o_srq_n;
    endproperty
    a_srq_hold: assert property (p_srq_hold) else $error("service request dropped early"); // [RULE_22]

    property p_dt_read;
        @(posedge i_mclk) disable iff (i_reset)
        i_cmd_valid && !i_cmd_write && i_cmd_reg == `REG_DEV_TYPE
            |=> o_rsp_status == ST_AEA && o_rsp_data == 16'h0008 && ptr == 22'h01_0000;
    endproperty
    a_dt_read: assert property (p_dt_read) else $error("long field read not preset"); // [RULE_12]

    property p_past_end;
        @(posedge i_mclk) disable iff (i_reset)
        o_rsp_valid && o_rsp_reg == `REG_EXT_DATA && o_rsp_status == ST_XE |-> o_rsp_data == 16'h0000;
    endproperty
    a_past_end: assert property (p_past_end) else $error("error read returned data"); // [RULE_13]

    property p_advance;
        @(posedge i_mclk) disable iff (i_reset)
        o_rsp_valid && o_rsp_reg == `REG_EXT_DATA && o_rsp_status == ST_OK
            |-> ptr == $past(ptr) + 22'h00_0002;
    endproperty
    a_advance: assert property (p_advance) else $error("contents pointer did not advance"); // [RULE_10]

    c_dt_walk: cover property (@(posedge i_mclk) disable iff (i_reset)
        o_rsp_valid && o_rsp_reg == `REG_EXT_DATA && o_rsp_status == ST_XE && ptr == 22'h01_0008);
    c_srq: cover property (@(posedge i_mclk) disable iff (i_reset) $fell(o_srq_n));
    c_cip: cover property (@(posedge i_mclk) disable iff (i_reset)
        i_cmd_valid && start ##2 (i_cmd_valid && xe && err_d == `ERR_PENDING));

endmodule : register_command_interpreter

// File: verification/reg_cmd_host_model.sv
// Host controller model that sends register commands and collects the responses.
`timescale 1ns/1ps
module reg_cmd_host_model
    import reg_cmd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rsp_valid,
    input wire rsp_status_t i_rsp_status,
    input wire logic [7:0] i_rsp_reg,
    input wire logic [15:0] i_rsp_data,
    output logic o_cmd_valid,
    output logic o_cmd_write,
    output logic [7:0] o_cmd_reg,
    output logic [15:0] o_cmd_data
);
    // ============================================================
    // Idle levels
    // The command lines start quiet so the device sees no request at time zero.
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_write = 1'b0;
        o_cmd_reg = 8'h00;
        o_cmd_data = 16'h0000;
    end

    // ============================================================
    // One command and its response
    // A command is one rw bit, a register number and two data bytes.
    task automatic xfer(input logic w, input logic [7:0] r, input logic [15:0] d,
            output rsp_status_t st, output logic [7:0] rr, output logic [15:0] rd,
            output logic ok);
        int k;
        ok = 1'b0;
        @(posedge i_mclk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd_write = w;
        o_cmd_reg = r;
        o_cmd_data = d;
        @(posedge i_mclk);
        #1;
        // Stale qualifiers are inverted so the device cannot lean on them.
        o_cmd_valid = 1'b0;
        o_cmd_write = ~w;
        o_cmd_reg = ~r;
        o_cmd_data = ~d;
        for (k = 0; k < 4 && !ok; k++) begin
            if (i_rsp_valid === 1'b1) begin
                st = i_rsp_status;
                rr = i_rsp_reg;
                rd = i_rsp_data;
                ok = 1'b1;
            end else begin
                @(posedge i_mclk);
                #1;
            end
        end
    endtask : xfer
endmodule : reg_cmd_host_model

// File: verification/register_command_interpreter_bench.sv
// Self-checking bench for the register command interpreter.
`timescale 1ns/1ps
`include "reg_cmd_defines.svh"
module register_command_interpreter_bench
    import reg_cmd_pkg::*;
;
    // Short long-op count keeps the run brief; pending checks fit well inside it.
    localparam int OP_CYCLES = 40;
    // Device type text; the value is arbitrary, null terminated.
    localparam logic [63:0] TYPE_TEXT = 64'h5859_5A20_3132_3300;
    logic i_mclk, i_reset, i_op_fault;
    logic cmd_valid, cmd_write, rsp_valid, srq_n;
    logic [7:0] cmd_reg, rsp_reg;
    logic [15:0] cmd_data, rsp_data;
    rsp_status_t rsp_status;
    int mismatches = 0;
    int tests_run = 0;

    // ============================================================
    // Clock and instances
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    register_command_interpreter #(.LONG_OP_CYCLES(OP_CYCLES), .DEV_TYPE_TEXT(TYPE_TEXT))
    register_command_interpreter_inst (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_reg(cmd_reg),
        .i_cmd_data(cmd_data), .i_op_fault(i_op_fault), .o_rsp_valid(rsp_valid),
        .o_rsp_status(rsp_status), .o_rsp_reg(rsp_reg), .o_rsp_data(rsp_data),
        .o_srq_n(srq_n));

    reg_cmd_host_model reg_cmd_host_model_inst (.i_mclk(i_mclk), .i_rsp_valid(rsp_valid),
        .i_rsp_status(rsp_status), .i_rsp_reg(rsp_reg), .i_rsp_data(rsp_data),
        .o_cmd_valid(cmd_valid), .o_cmd_write(cmd_write), .o_cmd_reg(cmd_reg),
        .o_cmd_data(cmd_data));

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // Sends one command and judges status, register echo and, when asked, data.
    task automatic cmd(input logic w, input logic [7:0] r, input logic [15:0] d,
            input rsp_status_t est, input logic dchk, input logic [15:0] ed,
            output logic [15:0] got);
        rsp_status_t st;
        logic [7:0] rr;
        logic ok;
        reg_cmd_host_model_inst.xfer(w, r, d, st, rr, got, ok);
        if (ok !== 1'b1) begin
            // A missing answer ends the run here as a failure.
            mismatches++;
            summarize();
        end else begin
            check({30'h0, st}, {30'h0, est});
            check({24'h0, rr}, {24'h0, r});
            if (dchk) begin
                check({16'h0, got}, {16'h0, ed});
            end
        end
    endtask : cmd

    // Reads carry junk data, which the device must ignore.
    task automatic rd(input logic [7:0] r, input rsp_status_t est, input logic [15:0] ed);
        logic [15:0] g;
        cmd(1'b0, r, 16'hFFFF, est, 1'b1, ed, g);
    endtask : rd

    // Writes only judge data when refused, since a refusal returns zero.
    task automatic wr(input logic [7:0] r, input logic [15:0] d, input rsp_status_t est);
        logic [15:0] g;
        cmd(1'b1, r, d, est, est == ST_XE, 16'h0000, g);
    endtask : wr

    // ============================================================
    // Scenarios
    task automatic s_reset();
        check({30'h0, srq_n, rsp_valid}, 32'h2);
        rd(`REG_OP_STATUS, ST_OK, 16'h0000);
        rd(`REG_FATAL, ST_OK, 16'h0000);
    endtask : s_reset

    // Holes in all three ranges and writes to read-only registers.
    task automatic s_unimpl();
        logic [7:0] holes [6] = '{8'h02, 8'h1F, 8'h21, 8'h7F, 8'h80, 8'hFF};
        foreach (holes[i]) begin
            rd(holes[i], ST_XE, 16'h0000);
            rd(`REG_OP_STATUS, ST_OK, {12'h0, `ERR_UNIMPL});
            wr(`REG_OP_STATUS, 16'h0000, ST_OK);
        end
        wr(`REG_DEV_TYPE, 16'h1234, ST_XE);
        rd(`REG_OP_STATUS, ST_OK, {12'h0, `ERR_READ_ONLY});
        wr(`REG_FATAL, 16'h0001, ST_XE);
        rd(`REG_OP_STATUS, ST_OK, {12'h0, `ERR_READ_ONLY});
        wr(`REG_OP_STATUS, 16'h0000, ST_OK);
    endtask : s_unimpl

    // Type text walk, one word too far, then a write into the read-only field.
    task automatic s_devtype();
        rd(`REG_DEV_TYPE, ST_AEA, `DT_LEN);
        rd(`REG_EXT_CFG, ST_OK, 16'h0001);
        rd(`REG_EXT_ADDR, ST_OK, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rd(`REG_EXT_DATA, ST_OK, TYPE_TEXT[63-16*i -: 16]);
        end
        rd(`REG_EXT_DATA, ST_XE, 16'h0000);
        rd(`REG_OP_STATUS, ST_OK, {12'h0, `ERR_EXT_RANGE});
        rd(`REG_EXT_ADDR, ST_OK, 16'h0008);
        wr(`REG_EXT_ADDR, 16'h0000, ST_OK);
        wr(`REG_EXT_DATA, 16'hBEEF, ST_XE);
        rd(`REG_OP_STATUS, ST_OK, {12'h0, `ERR_EXT_RO});
        wr(`REG_OP_STATUS, 16'h0000, ST_OK);
    endtask : s_devtype

    // Fill the label field word by word, overrun it, read it back, then aim by hand.
    task automatic s_label();
        logic [15:0] g;
        cmd(1'b1, `REG_LABEL, 16'h0000, ST_OK, 1'b1, `LB_LEN, g);
        for (int i = 0; i < 8; i++) begin
            wr(`REG_EXT_DATA, 16'hA000 | 16'(i), ST_OK);
        end
        wr(`REG_EXT_DATA, 16'h5555, ST_XE);
        rd(`REG_OP_STATUS, ST_OK, {12'h0, `ERR_EXT_RANGE});
        rd(`REG_LABEL, ST_AEA, `LB_LEN);
        rd(`REG_EXT_CFG, ST_OK, 16'h0002);
        for (int i = 0; i < 8; i++) begin
            rd(`REG_EXT_DATA, ST_OK, 16'hA000 | 16'(i));
        end
        wr(`REG_EXT_CFG, 16'h0002, ST_OK);
        wr(`REG_EXT_ADDR, 16'h000E, ST_OK);
        rd(`REG_EXT_DATA, ST_OK, 16'hA007);
        rd(`REG_EXT_DATA, ST_XE, 16'h0000);
        wr(`REG_OP_STATUS, 16'h0000, ST_OK);
    endtask : s_label

    // Reset in mid-run returns the pointer and the error field to zero.
    task automatic s_rerun();
        wr(`REG_DEV_TYPE, 16'h0000, ST_XE);
        @(posedge i_mclk);
        #1;
        i_reset = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        i_reset = 1'b0;
        rd(`REG_EXT_CFG, ST_OK, 16'h0000);
        rd(`REG_OP_STATUS, ST_OK, 16'h0000);
    endtask : s_rerun

    // A slow operation, overlapped commands, completion by polling and the service request.
    task automatic s_long_op(input logic fault, input logic en);
        logic [15:0] g;
        @(posedge i_mclk);
        #1;
        i_op_fault = fault;
        wr(`REG_SRQ_CFG, {15'h0, en}, ST_OK);
        rd(`REG_SRQ_CFG, ST_OK, {15'h0, en});
        wr(`REG_LONG_OP, 16'h0055, ST_PEND);
        rd(`REG_OP_STATUS, ST_OK, 16'h0100);
        wr(`REG_LONG_OP, 16'h0066, ST_XE);
        rd(`REG_OP_STATUS, ST_OK, 16'h0104);
        // The refused write must leave the running target untouched.
        rd(`REG_LONG_OP, ST_OK, 16'h0055);
        wr(`REG_OP_STATUS, 16'h0000, ST_OK);
        g = 16'h0100;
        for (int n = 0; n < 60 && g[8] !== 1'b0; n++) begin
            cmd(1'b0, `REG_OP_STATUS, 16'h0000, ST_OK, 1'b0, 16'h0000, g);
        end
        check({16'h0, g}, fault ? 32'h0008 : 32'h0000);
        check({31'h0, srq_n}, {31'h0, ~(fault & en)});
        rd(`REG_FATAL, ST_OK, {15'h0, fault & en});
        repeat (3) @(posedge i_mclk);
        check({31'h0, srq_n}, {31'h0, ~(fault & en)});
        wr(`REG_OP_STATUS, 16'h0000, ST_OK);
        check({31'h0, srq_n}, 32'h1);
        rd(`REG_OP_STATUS, ST_OK, 16'h0000);
        i_op_fault = 1'b0;
    endtask : s_long_op

    // ============================================================
    // Main sequence and watchdog
    initial begin
        i_reset = 1'b1;
        i_op_fault = 1'b0;
        repeat (10) @(posedge i_mclk);
        #1;
        i_reset = 1'b0;
        s_reset();
        s_unimpl();
        s_devtype();
        s_label();
        s_rerun();
        s_long_op(1'b1, 1'b1);
        s_long_op(1'b0, 1'b1);
        s_long_op(1'b1, 1'b0);
        summarize();
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        #(50 * 20000);
        mismatches++;
        summarize();
    end
endmodule : register_command_interpreter_bench
